// >>> crxf0_regs.sv
`timescale 1ns/100ps
`include "crxf0_cfg.svh"
module crxf0_regs
    import crxf0_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            arst_n_i,
    input  wire crxf0_bus_req_t  bus_req_i,
    output logic [31:0]          bus_rdata_o,
    input  wire logic            cfg_unlocked_i,
    input  wire crxf0_buf_evt_t  buf_update_i,
    input  wire logic            fifo0_store_i,
    output logic                 fifo0_store_ok_o,
    output logic [5:0]           fifo0_store_index_o,
    output crxf0_fifo_cfg_t      fifo0_cfg_o,
    output logic                 irq_o
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic hit_nd;
    logic hit_cfg;
    logic hit_ack;
    logic hit_irq;
    logic hit_msk;
    logic wr_nd;
    logic wr_cfg;
    logic wr_ack;
    logic wr_irq;
    logic wr_msk;

    assign hit_nd  = (bus_req_i.addr == `CRXF0_OFS_NEW_DATA_UPPER);
    assign hit_cfg = (bus_req_i.addr == `CRXF0_OFS_FIFO0_CONFIG);
    assign hit_ack = (bus_req_i.addr == `CRXF0_OFS_FIFO0_ACK);
    assign hit_irq = (bus_req_i.addr == `CRXF0_OFS_IRQ_STATUS);
    assign hit_msk = (bus_req_i.addr == `CRXF0_OFS_IRQ_MASK);

    // a locked config write is dropped whole, not field by field
    assign wr_cfg = bus_req_i.wr && hit_cfg && cfg_unlocked_i;
    assign wr_nd  = bus_req_i.wr && hit_nd;
    assign wr_ack = bus_req_i.wr && hit_ack;
    assign wr_irq = bus_req_i.wr && hit_irq;
    assign wr_msk = bus_req_i.wr && hit_msk;

    // ------------------------------------------------------------
    // new-data flags, buffers 32..63
    // ------------------------------------------------------------
    logic [31:0] new_data_upper_flags;
    logic [31:0] nd_set;
    logic [31:0] nd_clr;
    logic [31:0] next_new_data_upper_flags;
    logic        upd_upper;

    // lower-bank updates belong to the other register and are ignored
    assign upd_upper = buf_update_i.valid && buf_update_i.index[5];

    generate
        for (genvar b = 0; b < 32; b++) begin : g_nd
            assign nd_set[b] = upd_upper
                               && (buf_update_i.index[4:0] == 5'(b));
            assign nd_clr[b] = wr_nd && bus_req_i.wdata[b];
            // set wins so an update racing the clear is not lost
            assign next_new_data_upper_flags[b] =
                nd_set[b] | (new_data_upper_flags[b] & ~nd_clr[b]);
        end
    endgenerate

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            new_data_upper_flags <= `CRXF0_RST_WORD;
        end else begin
            new_data_upper_flags <= next_new_data_upper_flags;
        end
    end

    // ------------------------------------------------------------
    // fifo 0 configuration
    // ------------------------------------------------------------
    crxf0_fifo_cfg_t cfg;
    crxf0_fifo_cfg_t cfg_wr;

    // reserved bits 23, 1 and 0 are never captured
    assign cfg_wr.overwrite  = bus_req_i.wdata[`CRXF0_CFG_MODE_BIT];
    assign cfg_wr.watermark  =
        bus_req_i.wdata[`CRXF0_CFG_WM_HI:`CRXF0_CFG_WM_LO];
    assign cfg_wr.size       =
        bus_req_i.wdata[`CRXF0_CFG_SIZE_HI:`CRXF0_CFG_SIZE_LO];
    assign cfg_wr.start_addr =
        bus_req_i.wdata[`CRXF0_CFG_SA_HI:`CRXF0_CFG_SA_LO];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg <= '0;
        end else if (wr_cfg) begin
            cfg <= cfg_wr;
        end
    end

    assign fifo0_cfg_o = cfg;

    // oversize clamps to the maximum element count
    logic [6:0] size_eff;
    assign size_eff = (cfg.size > `CRXF0_MAX_ELEMS) ? `CRXF0_MAX_ELEMS
                                                    : cfg.size;

    // ------------------------------------------------------------
    // index helper
    // ------------------------------------------------------------
    // indices wrap at the clamped (effective) size, not at the field width
    function automatic logic [5:0] wrap_inc(input logic [5:0] x,
                                            input logic [6:0] sz);
        logic [6:0] nx;
        nx = {1'b0, x} + 7'h01;
        wrap_inc = (nx >= sz) ? 6'h00 : nx[5:0];
    endfunction : wrap_inc

    // ------------------------------------------------------------
    // fifo 0 pointers and fill level
    // ------------------------------------------------------------
    logic [5:0] fifo0_put_index;
    logic [5:0] fifo0_get_index;
    logic [6:0] fifo0_fill_level;
    logic [5:0] next_put;
    logic [5:0] next_get;
    logic [6:0] next_fill;
    logic       store_ok;
    logic       store_lost;
    logic       fifo0_full;

    // size zero means no fifo, so it can never read full
    assign fifo0_full = (size_eff != 7'h00)
                        && (fifo0_fill_level == size_eff);

    // ------------------------------------------------------------
    // acknowledge: new get index and the fill it leaves behind
    // ------------------------------------------------------------
    logic       ack_take;
    logic [5:0] ack_index;
    logic [5:0] ack_get;
    logic [6:0] ack_fill;

    // with no fifo there is nothing to acknowledge
    assign ack_take  = wr_ack && (size_eff != 7'h00);
    assign ack_index = bus_req_i.wdata[`CRXF0_ACK_HI:`CRXF0_ACK_LO];
    assign ack_get   = wrap_inc(ack_index, size_eff);

    always_comb begin
        if (ack_get == fifo0_put_index) begin
            ack_fill = 7'h00;
        end else if (fifo0_put_index > ack_get) begin
            ack_fill = 7'({1'b0, fifo0_put_index} - {1'b0, ack_get});
        end else begin
            // the unread span wraps past the last element
            ack_fill = 7'({1'b0, fifo0_put_index} + size_eff
                          - {1'b0, ack_get});
        end
    end

    always_comb begin
        next_put   = fifo0_put_index;
        next_get   = fifo0_get_index;
        next_fill  = fifo0_fill_level;
        store_ok   = 1'b0;
        store_lost = 1'b0;
        // ack is applied first so a same-cycle store sees freed room
        if (ack_take) begin
            next_get  = ack_get;
            next_fill = ack_fill;
        end
        if (fifo0_store_i) begin
            if (size_eff == 7'h00) begin
                store_lost = 1'b1;
            end else if (next_fill == size_eff) begin
                if (cfg.overwrite) begin
                    store_ok = 1'b1;
                    next_put = wrap_inc(next_put, size_eff);
                    next_get = wrap_inc(next_get, size_eff);
                end else begin
                    store_lost = 1'b1;
                end
            end else begin
                store_ok  = 1'b1;
                next_put  = wrap_inc(next_put, size_eff);
                next_fill = next_fill + 7'h01;
            end
        end
        // a new geometry restarts the fifo empty
        if (wr_cfg) begin
            next_put  = 6'h00;
            next_get  = 6'h00;
            next_fill = 7'h00;
            store_ok  = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fifo0_put_index <= '0;
        end else begin
            fifo0_put_index <= next_put;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fifo0_get_index <= '0;
        end else begin
            fifo0_get_index <= next_get;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fifo0_fill_level <= '0;
        end else begin
            fifo0_fill_level <= next_fill;
        end
    end

    // ------------------------------------------------------------
    // answer to the protocol engine
    // ------------------------------------------------------------
    // the engine writes at the current put index when told ok
    assign fifo0_store_ok_o    = store_ok;
    assign fifo0_store_index_o = fifo0_put_index;

    // ------------------------------------------------------------
    // interrupt flags and mask
    // ------------------------------------------------------------
    logic [`CRXF0_IRQ_BITS-1:0] irq_status;
    logic [`CRXF0_IRQ_BITS-1:0] irq_mask;
    logic [`CRXF0_IRQ_BITS-1:0] irq_set;
    logic                       wm_valid;

    assign wm_valid = (cfg.watermark != 7'h00)
                      && (cfg.watermark <= `CRXF0_MAX_ELEMS);

    // edge on the level, so a fifo parked at the mark fires only once
    logic wm_reached;
    logic became_full;

    assign wm_reached  = wm_valid && store_ok
                         && (next_fill == cfg.watermark)
                         && (fifo0_fill_level != cfg.watermark);
    assign became_full = store_ok && (next_fill == size_eff)
                         && (fifo0_fill_level != size_eff);

    always_comb begin
        irq_set = '0;
        irq_set[`CRXF0_IRQ_LOST] = store_lost;
        irq_set[`CRXF0_IRQ_WM]   = wm_reached;
        irq_set[`CRXF0_IRQ_FULL] = became_full;
        irq_set[`CRXF0_IRQ_NEW]  = store_ok;
    end

    logic [`CRXF0_IRQ_BITS-1:0] irq_clr;
    logic [`CRXF0_IRQ_BITS-1:0] next_irq_status;

    generate
        for (genvar i = 0; i < `CRXF0_IRQ_BITS; i++) begin : g_irq
            assign irq_clr[i] = wr_irq && bus_req_i.wdata[i];
            // set wins over a simultaneous clear
            assign next_irq_status[i] =
                irq_set[i] | (irq_status[i] & ~irq_clr[i]);
        end
    endgenerate

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_status <= `CRXF0_RST_IRQ;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_mask <= `CRXF0_RST_IRQ;
        end else if (wr_msk) begin
            irq_mask <= bus_req_i.wdata[`CRXF0_IRQ_BITS-1:0];
        end
    end

    // level output, drops as soon as software clears or masks the cause
    assign irq_o = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // readback words, reserved bits forced to zero
    // ------------------------------------------------------------
    logic [31:0] cfg_word;
    logic [31:0] status_word;

    always_comb begin
        cfg_word = `CRXF0_RST_WORD;
        cfg_word[`CRXF0_CFG_MODE_BIT] = cfg.overwrite;
        cfg_word[`CRXF0_CFG_WM_HI:`CRXF0_CFG_WM_LO] = cfg.watermark;
        cfg_word[`CRXF0_CFG_SIZE_HI:`CRXF0_CFG_SIZE_LO] = cfg.size;
        cfg_word[`CRXF0_CFG_SA_HI:`CRXF0_CFG_SA_LO] = cfg.start_addr;
    end

    // lost bit is the interrupt flag itself, so one clear serves both
    always_comb begin
        status_word = `CRXF0_RST_WORD;
        status_word[`CRXF0_ST_LOST_BIT] =
            irq_status[`CRXF0_IRQ_LOST];
        status_word[`CRXF0_ST_FULL_BIT] = fifo0_full;
        status_word[`CRXF0_ST_PUT_HI:`CRXF0_ST_PUT_LO] =
            fifo0_put_index;
        status_word[`CRXF0_ST_GET_HI:`CRXF0_ST_GET_LO] =
            fifo0_get_index;
        status_word[`CRXF0_ST_FILL_HI:`CRXF0_ST_FILL_LO] =
            fifo0_fill_level;
    end

    // ------------------------------------------------------------
    // read path, data one cycle after the strobe
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = `CRXF0_RST_WORD;
        unique case (bus_req_i.addr)
            `CRXF0_OFS_NEW_DATA_UPPER: begin
                rd_mux = new_data_upper_flags;
            end
            `CRXF0_OFS_FIFO0_CONFIG: begin
                rd_mux = cfg_word;
            end
            `CRXF0_OFS_FIFO0_STATUS: begin
                rd_mux = status_word;
            end
            `CRXF0_OFS_IRQ_STATUS: begin
                rd_mux[`CRXF0_IRQ_BITS-1:0] = irq_status;
            end
            `CRXF0_OFS_IRQ_MASK: begin
                rd_mux[`CRXF0_IRQ_BITS-1:0] = irq_mask;
            end
            default: begin
                rd_mux = `CRXF0_RST_WORD;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_rdata_o <= `CRXF0_RST_WORD;
        end else if (bus_req_i.rd) begin
            // idle cycles return zero so a stale word is never seen
            bus_rdata_o <= rd_mux;
        end else begin
            bus_rdata_o <= `CRXF0_RST_WORD;
        end
    end

endmodule : crxf0_regs

// >>> crxf0_cfg.svh
`ifndef CRXF0_CFG_SVH
`define CRXF0_CFG_SVH

// register offsets
`define CRXF0_OFS_NEW_DATA_UPPER  8'h9C
`define CRXF0_OFS_FIFO0_CONFIG    8'hA0
`define CRXF0_OFS_FIFO0_STATUS    8'hA4
`define CRXF0_OFS_FIFO0_ACK       8'hA8
`define CRXF0_OFS_IRQ_STATUS      8'hC0
`define CRXF0_OFS_IRQ_MASK        8'hC4

// configuration field positions
`define CRXF0_CFG_MODE_BIT        31
`define CRXF0_CFG_WM_HI           30
`define CRXF0_CFG_WM_LO           24
`define CRXF0_CFG_SIZE_HI         22
`define CRXF0_CFG_SIZE_LO         16
`define CRXF0_CFG_SA_HI           15
`define CRXF0_CFG_SA_LO           2

// status field positions
`define CRXF0_ST_LOST_BIT         25
`define CRXF0_ST_FULL_BIT         24
`define CRXF0_ST_PUT_HI           21
`define CRXF0_ST_PUT_LO           16
`define CRXF0_ST_GET_HI           13
`define CRXF0_ST_GET_LO           8
`define CRXF0_ST_FILL_HI          6
`define CRXF0_ST_FILL_LO          0

// acknowledge field
`define CRXF0_ACK_HI              5
`define CRXF0_ACK_LO              0

// interrupt bit positions
`define CRXF0_IRQ_LOST            0
`define CRXF0_IRQ_WM              1
`define CRXF0_IRQ_FULL            2
`define CRXF0_IRQ_NEW             3
`define CRXF0_IRQ_BITS            4

// limits and reset values
`define CRXF0_MAX_ELEMS           7'h40
`define CRXF0_RST_WORD            32'h0000_0000
`define CRXF0_RST_IRQ             4'h0

`endif

// >>> crxf0_pkg.sv
package crxf0_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } crxf0_bus_req_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] index;
    } crxf0_buf_evt_t;

    typedef struct packed {
        logic        overwrite;
        logic [6:0]  watermark;
        logic [6:0]  size;
        logic [13:0] start_addr;
    } crxf0_fifo_cfg_t;

endpackage : crxf0_pkg

// >>> crxf0_regs_assertions.sv
`timescale 1ns/100ps
module crxf0_regs_checker
    import crxf0_pkg::*;
(
    input wire logic            clk_i,
    input wire logic            arst_n_i,
    input wire crxf0_bus_req_t  bus_req_i,
    input wire logic [31:0]     bus_rdata_o,
    input wire logic            cfg_unlocked_i,
    input wire crxf0_buf_evt_t  buf_update_i,
    input wire logic            fifo0_store_i,
    input wire logic            fifo0_store_ok_o,
    input wire logic [5:0]      fifo0_store_index_o,
    input wire crxf0_fifo_cfg_t fifo0_cfg_o,
    input wire logic            irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // ----------------
    // helpers
    // ----------------
    crxf0_fifo_cfg_t w;
    logic [31:0]     cw;
    logic [6:0]      eff;
    logic [6:0]      nxt;
    logic            wcfg;
    assign w    = {bus_req_i.wdata[31:24], bus_req_i.wdata[22:2]};
    assign cw   = {fifo0_cfg_o[28:21], 1'h0, fifo0_cfg_o[20:0], 2'h0};
    assign wcfg = bus_req_i.wr && bus_req_i.addr == 8'hA0 && cfg_unlocked_i;
    assign eff  = fifo0_cfg_o.size > 7'h40 ? 7'h40 : fifo0_cfg_o.size;
    // wrap at the effective size, not at the index width
    assign nxt  = fifo0_store_index_o + 7'h1 == eff ? 7'h0
                : fifo0_store_index_o + 7'h1;

    a_cfg_locked: assert property (
        $changed(fifo0_cfg_o) |-> $past(wcfg)) else $error("cfg lock");
    a_cfg_load: assert property (
        wcfg |=> fifo0_cfg_o == $past(w)) else $error("cfg load");
    a_cfg_read: assert property (
        bus_req_i.rd && bus_req_i.addr == 8'hA0 |=> bus_rdata_o == $past(cw))
        else $error("cfg read");
    a_unmapped_zero: assert property (
        bus_req_i.rd && bus_req_i.addr == 8'hB0 |=> bus_rdata_o == 32'h0)
        else $error("unmapped read");
    a_size0_drop: assert property (
        fifo0_store_i && fifo0_cfg_o.size == 7'h0 |-> !fifo0_store_ok_o)
        else $error("size zero store");
    a_ovw_accept: assert property (
        fifo0_store_i && fifo0_cfg_o.size != 7'h0 && fifo0_cfg_o.overwrite
        && !wcfg |-> fifo0_store_ok_o) else $error("overwrite refused");
    a_put_step: assert property (
        fifo0_store_i && fifo0_store_ok_o && !bus_req_i.wr
        |=> {1'h0, fifo0_store_index_o} == $past(nxt)) else $error("put");
    a_put_hold: assert property (
        !fifo0_store_i && !bus_req_i.wr |=> $stable(fifo0_store_index_o))
        else $error("put moved");
endmodule : crxf0_regs_checker

bind crxf0_regs crxf0_regs_checker crxf0_regs_checker_i (
    .clk_i, .arst_n_i, .bus_req_i, .bus_rdata_o, .cfg_unlocked_i,
    .buf_update_i, .fifo0_store_i, .fifo0_store_ok_o,
    .fifo0_store_index_o, .fifo0_cfg_o, .irq_o);

// >>> crxf0_host.sv
`timescale 1ns/100ps
module crxf0_host
    import crxf0_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic [31:0] bus_rdata_i,
    output crxf0_bus_req_t   bus_req_o
);
    initial bus_req_o = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        bus_req_o <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: v};
        @(posedge clk_i);
        bus_req_o.wr <= 1'h0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        bus_req_o <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
        @(posedge clk_i);
        bus_req_o.rd <= 1'h0;
        @(posedge clk_i);
        v = bus_rdata_i;
    endtask : rd
    task automatic ack(input logic [5:0] k);
        wr(8'hA8, {26'h0, k});
    endtask : ack
    task automatic clr(input logic [31:0] m);
        wr(8'h9C, m);
    endtask : clr
endmodule : crxf0_host

// >>> crxf0_regs_test.sv
`timescale 1ns/100ps
module crxf0_regs_test
    import crxf0_pkg::*;
;
    logic           clk_i = 1'h0;
    logic           arst_n_i = 1'h0;
    crxf0_bus_req_t req;
    crxf0_buf_evt_t upd = '0;
    logic [31:0]    rdata, d, nd, m;
    logic           unlk = 1'h0;
    logic           st = 1'h0;
    logic           irq;
    int             error_cnt = 0, num_checks = 0;
    int             seed = 32'hd8d28363, sz, k;

    crxf0_host host (.clk_i(clk_i), .bus_rdata_i(rdata), .bus_req_o(req));
    crxf0_regs crxf0_regs_i (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .bus_req_i(req),
        .bus_rdata_o(rdata), .cfg_unlocked_i(unlk), .buf_update_i(upd),
        .fifo0_store_i(st), .fifo0_store_ok_o(), .fifo0_store_index_o(),
        .fifo0_cfg_o(), .irq_o(irq));

    initial forever #5 clk_i = ~clk_i;
    initial begin
        #50000;
        error_cnt++;
        summarize();
    end
    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] sts(logic l, f, logic [5:0] p, g,
                                        logic [6:0] fl);
        return {6'h0, l, f, 2'h0, p, 2'h0, g, 1'h0, fl};
    endfunction : sts
    function automatic logic [31:0] cfgw(logic o, logic [6:0] wm, s,
                                         logic [13:0] sa);
        return {o, wm, 1'h0, s, sa, 2'h0};
    endfunction : cfgw
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        host.rd(a, d);
        chk(d, exp);
    endtask : rchk
    task automatic store(input int n);
        repeat (n) @(posedge clk_i) st <= 1'h1;
        @(posedge clk_i) st <= 1'h0;
    endtask : store
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    initial begin
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'h1;
        rchk(8'h9C, 32'h0);
        rchk(8'hA4, 32'h0);
        nd = 32'h0;
        repeat (4) begin
            repeat (6) begin
                k = $random(seed);
                @(posedge clk_i) upd <= '{valid: 1'h1, index: k[5:0]};
                if (k[5]) nd[k[4:0]] = 1'h1;
            end
            @(posedge clk_i) upd <= '0;
            rchk(8'h9C, nd);
            m = $random(seed);
            host.clr(m);
            nd &= ~m;
            rchk(8'h9C, nd);
        end
        host.wr(8'hA0, $random(seed));
        rchk(8'hA0, 32'h0);
        unlk <= 1'h1;
        m = $random(seed);
        host.wr(8'hA0, m);
        rchk(8'hA0, m & 32'hFF7F_FFFC);
        host.wr(8'hA4, 32'hFFFF_FFFF);
        rchk(8'hA4, 32'h0);
        rchk(8'hB0, 32'h0);
        host.wr(8'hC4, 32'h1);
        host.wr(8'hA0, cfgw(1'h0, 7'h0, 7'h0, 14'h0));
        store(1);
        rchk(8'hA4, sts(1'h1, 1'h0, 6'h0, 6'h0, 7'h0));
        chk(irq, 32'h1);
        host.wr(8'hC4, 32'h0);
        @(posedge clk_i);
        chk(irq, 32'h0);
        host.wr(8'hC0, 32'h1);
        rchk(8'hA4, 32'h0);
        sz = 1 + ($random(seed) & 7);
        host.wr(8'hA0, cfgw(1'h0, 7'(sz), 7'(sz), 14'h1A5));
        store(sz + 1);
        rchk(8'hA4, sts(1'h1, 1'h1, 6'h0, 6'h0, 7'(sz)));
        rchk(8'hC0, 32'hF);
        host.wr(8'hC0, 32'hF);
        k = ($random(seed) & 7) % sz;
        host.ack(6'(k));
        rchk(8'hA4, sts(1'h0, 1'h0, 6'h0, 6'((k + 1) % sz),
                        7'((sz - (k + 1) % sz) % sz)));
        host.wr(8'hA0, cfgw(1'h1, 7'h0, 7'h3, 14'h0));
        store(4);
        rchk(8'hA4, sts(1'h0, 1'h1, 6'h1, 6'h1, 7'h3));
        rchk(8'hC0, 32'hC);
        host.wr(8'hC0, 32'hF);
        host.wr(8'hA0, cfgw(1'h0, 7'h41, 7'h7F, 14'h3FFF));
        store(64);
        rchk(8'hA4, sts(1'h0, 1'h1, 6'h0, 6'h0, 7'h40));
        rchk(8'hC0, 32'hC);
        rchk(8'hA0, cfgw(1'h0, 7'h41, 7'h7F, 14'h3FFF));
        @(posedge clk_i) upd <= '{valid: 1'h1, index: 6'h3F};
        @(posedge clk_i) upd <= '0;
        arst_n_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'h1;
        rchk(8'h9C, 32'h0);
        summarize();
    end
endmodule : crxf0_regs_test
